// >>> inc/csf_defs.svh
// Constants of the status-flag datapath: flag positions, reset values
// and the stack page.  Included by the design and the bench files.
`ifndef CSF_DEFS_SVH
`define CSF_DEFS_SVH

`define CSF_FLAG_C 0
`define CSF_FLAG_Z 1
`define CSF_FLAG_I 2
`define CSF_FLAG_D 3
`define CSF_FLAG_B 4
`define CSF_FLAG_T 5
`define CSF_FLAG_V 6
`define CSF_FLAG_N 7

`define CSF_I_RESET     1'b1
`define CSF_ACC_RESET   8'h00
`define CSF_SP_RESET    8'hFF
`define CSF_STACK_PAGE  8'h01
`define CSF_DEC_LIMIT   5'h09
`define CSF_DEC_ADJUST  5'h06
`define CSF_DEC_MAX     9'h063

`endif

// >>> inc/csf_pkg.sv
// Types shared by the status-flag datapath and its arithmetic unit.
// Assumes nothing of its surroundings.
package csf_pkg;

  typedef enum logic [4:0] {
    add_with_carry_op       = 5'b00000,
    subtract_with_borrow_op = 5'b00001,
    and_op                  = 5'b00010,
    exclusive_or_op         = 5'b00011,
    inclusive_or_op         = 5'b00100,
    bit_set_op              = 5'b00101,
    bit_clear_op            = 5'b00110,
    shift_left_op           = 5'b00111,
    shift_right_op          = 5'b01000,
    rotate_left_op          = 5'b01001,
    rotate_right_op         = 5'b01010,
    nibble_rotate_op        = 5'b01011,
    increment_op            = 5'b01100,
    decrement_op            = 5'b01101,
    ones_complement_op      = 5'b01110,
    multiply_op             = 5'b01111,
    divide_op               = 5'b10000,
    push_status_op          = 5'b10001,
    pull_status_op          = 5'b10010,
    jump_op                 = 5'b10011,
    flag_set_op             = 5'b10100,
    flag_clear_op           = 5'b10101,
    load_acc_op             = 5'b10110,
    load_stack_op           = 5'b10111
  } csf_op_type;

  typedef struct packed {
    csf_op_type  op;
    logic [15:0] addr;
    logic [7:0]  data;
    logic [2:0]  bit_sel;
  } csf_cmd_type;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } csf_mem_req_type;

  typedef struct packed {
    logic [7:0] res;
    logic       n;
    logic       v;
    logic       z;
    logic       c;
    logic       upd_nz;
    logic       upd_v;
    logic       upd_c;
  } csf_alu_out_type;

  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_addr  = 2'b01,
    st_data  = 2'b10,
    st_write = 2'b11
  } csf_state_type;

endpackage

// >>> hdl/csf_alu.sv
// Combinational arithmetic and logic unit of the status-flag datapath.
// Assumes operands are stable for the cycle in which the result is used.
`timescale 1ns/10ps
`include "csf_defs.svh"
module csf_alu (
  // Operation and operands
  input  csf_pkg::csf_op_type      op,
  input  logic [7:0]               a,
  input  logic [7:0]               b,
  input  logic                     c_in,
  input  logic                     dec_mode,
  input  logic [2:0]               bit_sel,
  // Result and flags
  output csf_pkg::csf_alu_out_type result
);
  import csf_pkg::*;

  function automatic logic [8:0] bcd_add(input logic [7:0] x,
                                         input logic [7:0] y,
                                         input logic       ci);
    logic [4:0] lo;
    logic [4:0] hi;
    logic       lc;
    logic       hc;
    lo = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
    lc = lo > `CSF_DEC_LIMIT;
    if (lc) begin
      lo = lo + `CSF_DEC_ADJUST;
    end
    hi = {1'b0, x[7:4]} + {1'b0, y[7:4]} + {4'h0, lc};
    hc = hi > `CSF_DEC_LIMIT;
    if (hc) begin
      hi = hi + `CSF_DEC_ADJUST;
    end
    return {hc, hi[3:0], lo[3:0]};
  endfunction

  // Carry in clear means a borrow is pending; carry out clear is a borrow.
  function automatic logic [8:0] bcd_sub(input logic [7:0] x,
                                         input logic [7:0] y,
                                         input logic       ci);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, ~ci};
    hi = {1'b0, x[7:4]} - {1'b0, y[7:4]} - {4'h0, lo[4]};
    if (lo[4]) begin
      lo = lo - `CSF_DEC_ADJUST;
    end
    if (hi[4]) begin
      hi = hi - `CSF_DEC_ADJUST;
    end
    return {~hi[4], hi[3:0], lo[3:0]};
  endfunction

  function automatic csf_alu_out_type calc(input csf_op_type op_i,
                                           input logic [7:0] x,
                                           input logic [7:0] y,
                                           input logic       ci,
                                           input logic       dec,
                                           input logic [2:0] bs);
    csf_alu_out_type o;
    logic [8:0]      s;
    logic [7:0]      m;
    o = '0;
    s = '0;
    m = 8'h01 << bs;
    o.res = x;
    unique case (op_i)
      add_with_carry_op: begin
        s = dec ? bcd_add(x, y, ci)
                : {1'b0, x} + {1'b0, y} + {8'h00, ci};
        o.v = (x[7] == y[7]) && (s[7] != x[7]);
      end
      subtract_with_borrow_op: begin
        s = dec ? bcd_sub(x, y, ci)
                : {1'b0, x} + {1'b0, ~y} + {8'h00, ci};
        o.v = (x[7] != y[7]) && (s[7] != x[7]);
      end
      and_op:             o.res = x & y;
      exclusive_or_op:    o.res = x ^ y;
      inclusive_or_op:    o.res = x | y;
      bit_set_op:         o.res = x | m;
      bit_clear_op:       o.res = x & ~m;
      shift_left_op:      s = {x, 1'b0};
      shift_right_op:     s = {x[0], 1'b0, x[7:1]};
      rotate_left_op:     s = {x, ci};
      rotate_right_op:    s = {x[0], ci, x[7:1]};
      nibble_rotate_op:   o.res = {x[3:0], x[7:4]};
      increment_op:       o.res = x + 8'h01;
      decrement_op:       o.res = x - 8'h01;
      ones_complement_op: o.res = ~x;
      default:            o.res = x;
    endcase
    if (op_i inside {add_with_carry_op, subtract_with_borrow_op,
                     shift_left_op, shift_right_op, rotate_left_op,
                     rotate_right_op}) begin
      o.res   = s[7:0];
      o.c     = s[8];
      o.upd_c = 1'b1;
    end
    // Decimal N, V and Z come from the adjusted byte and mean nothing.
    o.upd_v  = op_i inside {add_with_carry_op, subtract_with_borrow_op};
    o.upd_nz = !(op_i inside {bit_set_op, bit_clear_op, nibble_rotate_op});
    o.n      = o.res[7];
    o.z      = (o.res == 8'h00);
    return o;
  endfunction

  assign result = calc(op, a, b, c_in, dec_mode, bit_sel);

endmodule

// >>> hdl/csf_core.sv
// Status-flag datapath of the 8-bit core: status byte, accumulator,
// stack pointer, read-modify-write sequencing and indirect jump pointer.
// Assumes a synchronous memory: data is valid the cycle after rd.
`timescale 1ns/10ps
`include "csf_defs.svh"
module csf_core #(
  parameter logic [7:0] STACK_PAGE = `CSF_STACK_PAGE
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // Decoded instruction command
  input  wire logic                      cmd_valid,
  input  csf_pkg::csf_cmd_type           cmd,
  output logic                           cmd_ready,
  output logic                           done,
  // Data memory and special function register bus
  output csf_pkg::csf_mem_req_type       mem,
  input  wire logic [7:0]                mem_rdata,
  // Architectural state
  output logic [7:0]                     processor_status_register,
  output logic [7:0]                     acc,
  output logic [7:0]                     sp,
  // Program counter load from indirect jump
  output logic                           pc_load,
  output logic [15:0]                    pc_target
);
  import csf_pkg::*;

  csf_state_type   state;
  csf_state_type   next_state;
  csf_cmd_type     cur;
  csf_cmd_type     next_cur;
  logic            rmw;
  logic            next_rmw;
  logic            hi_phase;
  logic            next_hi_phase;
  logic [7:0]      ptr_lo;
  logic [7:0]      next_ptr_lo;
  logic [7:0]      status;
  logic [7:0]      next_status;
  logic [7:0]      next_acc;
  logic [7:0]      next_sp;
  csf_mem_req_type next_mem;
  logic            next_done;
  logic            next_pc_load;
  logic [15:0]     next_pc_target;
  csf_alu_out_type alu_out;

  function automatic logic is_arith(input csf_op_type op);
    return op inside {add_with_carry_op, subtract_with_borrow_op, and_op,
                      exclusive_or_op, inclusive_or_op};
  endfunction

  function automatic logic [7:0] apply_flags(input logic [7:0]      st,
                                             input csf_alu_out_type o);
    logic [7:0] r;
    r = st;
    if (o.upd_nz) begin
      r[`CSF_FLAG_N] = o.n;
      r[`CSF_FLAG_Z] = o.z;
    end
    if (o.upd_v) begin
      r[`CSF_FLAG_V] = o.v;
    end
    if (o.upd_c) begin
      r[`CSF_FLAG_C] = o.c;
    end
    return r;
  endfunction

  wire        accept     = cmd_valid && cmd_ready;
  wire        t_mode     = status[`CSF_FLAG_T];
  wire        cmd_rmw    = (cmd.op inside {[bit_set_op:ones_complement_op]})
                           || (is_arith(cmd.op) && t_mode);
  wire [15:0] stack_addr = {STACK_PAGE, sp};
  wire [7:0]  sp_up      = sp + 8'h01;
  wire [15:0] pull_addr  = {STACK_PAGE, sp_up};
  wire [15:0] product    = acc * cmd.data;
  wire        div_zero   = (cmd.data == 8'h00);
  wire [7:0]  quotient   = div_zero ? 8'hFF : acc / cmd.data;
  wire [7:0]  remainder  = div_zero ? acc : acc % cmd.data;
  wire [7:0]  flag_mask  = 8'h01 << cmd.bit_sel;
  wire        in_idle    = (state == st_idle);
  // In idle the accumulator is the operand; later the memory byte is.
  wire [7:0]  alu_a      = in_idle ? acc : mem_rdata;
  wire [7:0]  pull_wdata = (cmd.op == push_status_op) ? status
                         : (cmd.op == multiply_op) ? product[15:8]
                         : remainder;

  assign cmd_ready                 = in_idle;
  assign processor_status_register = status;

  csf_alu u_alu (
    .op       (in_idle ? cmd.op : cur.op),
    .a        (alu_a),
    .b        (in_idle ? cmd.data : cur.data),
    .c_in     (status[`CSF_FLAG_C]),
    .dec_mode (status[`CSF_FLAG_D]),
    .bit_sel  (in_idle ? cmd.bit_sel : cur.bit_sel),
    .result   (alu_out)
  );

  always_comb begin
    next_state     = state;
    next_cur       = cur;
    next_rmw       = rmw;
    next_hi_phase  = hi_phase;
    next_ptr_lo    = ptr_lo;
    next_status    = status;
    next_acc       = acc;
    next_sp        = sp;
    next_mem       = mem;
    next_mem.rd    = 1'b0;
    next_mem.wr    = 1'b0;
    next_done      = 1'b0;
    next_pc_load   = 1'b0;
    next_pc_target = pc_target;
    unique case (state)
      st_idle: begin
        if (accept) begin
          next_cur      = cmd;
          next_rmw      = cmd_rmw;
          next_hi_phase = 1'b0;
          if (cmd_rmw || cmd.op == jump_op) begin
            next_mem.rd   = 1'b1;
            next_mem.addr = cmd.addr;
            next_state    = st_addr;
          end else if (cmd.op == pull_status_op) begin
            next_mem.rd   = 1'b1;
            next_mem.addr = pull_addr;
            next_sp       = sp_up;
            next_state    = st_addr;
          end else if (cmd.op inside {push_status_op, multiply_op,
                                      divide_op}) begin
            // Status is left alone by multiply and divide.
            next_mem.wr    = 1'b1;
            next_mem.addr  = stack_addr;
            next_mem.wdata = pull_wdata;
            next_sp        = sp - 8'h01;
            if (cmd.op == multiply_op) begin
              next_acc = product[7:0];
            end else if (cmd.op == divide_op) begin
              next_acc = quotient;
            end
            next_state = st_write;
          end else begin
            next_done = 1'b1;
            if (is_arith(cmd.op)) begin
              next_acc    = alu_out.res;
              next_status = apply_flags(status, alu_out);
            end else if (cmd.op == load_acc_op) begin
              next_acc = cmd.data;
            end else if (cmd.op == load_stack_op) begin
              next_sp = cmd.data;
            end else if (cmd.op == flag_set_op) begin
              next_status = status | flag_mask;
            end else if (cmd.op == flag_clear_op) begin
              next_status = status & ~flag_mask;
            end
          end
        end
      end
      st_addr: begin
        next_state = st_data;
      end
      st_data: begin
        if (cur.op == jump_op && !hi_phase) begin
          next_ptr_lo   = mem_rdata;
          next_hi_phase = 1'b1;
          next_mem.rd   = 1'b1;
          next_mem.addr = {mem.addr[15:8], mem.addr[7:0] + 8'h01};
          next_state    = st_addr;
        end else if (cur.op == jump_op) begin
          next_pc_target = {mem_rdata, ptr_lo};
          next_pc_load   = 1'b1;
          next_done      = 1'b1;
          next_state     = st_idle;
        end else if (cur.op == pull_status_op) begin
          next_status = mem_rdata;
          next_done   = 1'b1;
          next_state  = st_idle;
        end else begin
          // Whatever the read returned is modified and written back.
          next_mem.wr    = 1'b1;
          next_mem.wdata = alu_out.res;
          next_status    = apply_flags(status, alu_out);
          next_state     = st_write;
        end
      end
      st_write: begin
        next_done  = 1'b1;
        next_state = st_idle;
      end
    endcase
  end

  // Only interrupt disable has a reset value; other flags hold.
  always_ff @(posedge clk) begin
    if (rst) begin
      status[`CSF_FLAG_I] <= `CSF_I_RESET;
    end else begin
      status <= next_status;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state     <= st_idle;
      acc       <= `CSF_ACC_RESET;
      sp        <= `CSF_SP_RESET;
      mem       <= '0;
      done      <= 1'b0;
      pc_load   <= 1'b0;
      pc_target <= 16'h0000;
      hi_phase  <= 1'b0;
      rmw       <= 1'b0;
    end else begin
      state     <= next_state;
      acc       <= next_acc;
      sp        <= next_sp;
      mem       <= next_mem;
      done      <= next_done;
      pc_load   <= next_pc_load;
      pc_target <= next_pc_target;
      hi_phase  <= next_hi_phase;
      rmw       <= next_rmw;
    end
  end

  always_ff @(posedge clk) begin
    cur    <= next_cur;
    ptr_lo <= next_ptr_lo;
  end

  function automatic logic [8:0] bcd_value(input logic [7:0] x);
    return 9'(x[7:4]) * 9'h00A + 9'(x[3:0]);
  endfunction

  wire dec_add = accept && cmd.op == add_with_carry_op && !t_mode
                 && status[`CSF_FLAG_D] && acc[7:4] < 4'hA
                 && acc[3:0] < 4'hA && cmd.data[7:4] < 4'hA
                 && cmd.data[3:0] < 4'hA;
  wire [8:0] dec_sum = bcd_value(acc) + bcd_value(cmd.data)
                       + 9'(status[`CSF_FLAG_C]);

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  reset_int_disable_a:
    assert property ($past(rst) |-> status[`CSF_FLAG_I])
    else $error("interrupt disable not set after reset");
  decimal_carry_a:
    assert property (dec_add |=> status[`CSF_FLAG_C]
                     == ($past(dec_sum) > `CSF_DEC_MAX))
    else $error("decimal carry flag wrong");
  decimal_logic_a:
    assert property (accept && cmd.op == and_op && !t_mode
                     |=> acc == ($past(acc) & $past(cmd.data)))
    else $error("logic result altered by decimal mode");
  mul_product_a:
    assert property (accept && cmd.op == multiply_op
                     |=> acc == $past(product[7:0])
                     && mem.wdata == $past(product[15:8]))
    else $error("multiply result wrong");
  muldiv_status_a:
    assert property (accept && cmd.op inside {multiply_op, divide_op}
                     |=> $stable(status) [*2])
    else $error("status changed by multiply or divide");
  rmw_same_addr_a:
    assert property (state == st_data && rmw
                     |=> mem.wr && mem.addr == $past(mem.addr))
    else $error("read-modify-write address mismatch");
  t_mode_memory_a:
    assert property (accept && is_arith(cmd.op) && t_mode
                     |=> mem.rd ##2 mem.wr && $stable(acc))
    else $error("T mode operation did not write memory");
  push_status_a:
    assert property (accept && cmd.op == push_status_op
                     |=> mem.wr && mem.wdata == $past(status)
                     && mem.addr == {STACK_PAGE, $past(sp)}
                     && sp == $past(sp) - 8'h01)
    else $error("push status wrote wrong byte or address");
  pull_status_a:
    assert property (accept && cmd.op == pull_status_op
                     |=> mem.rd && mem.addr == {STACK_PAGE, sp}
                     ##1 1'b1 ##1 status == $past(mem_rdata) && done)
    else $error("pull status did not restore from stack");
  jump_page_wrap_a:
    assert property (accept && cmd.op == jump_op
                     |-> ##3 mem.rd
                     && mem.addr == {$past(cmd.addr[15:8], 3),
                                     $past(cmd.addr[7:0], 3) + 8'h01})
    else $error("indirect jump pointer left its page");

endmodule

// >>> test/csf_mem_model.sv
// Behavioural data memory and register bus that faces the core.
// Assumes one shared clock and one-cycle rd and wr pulses from the core.
`timescale 1ns/10ps
module csf_mem_model #(
  parameter logic [15:0] UNREADABLE_ADDR = 16'h00F0
) (
  // Clock
  input  wire logic                clk,
  // Bus from the core
  input  csf_pkg::csf_mem_req_type mem,
  output logic [7:0]               mem_rdata
);
  import csf_pkg::*;
  logic [7:0] store [0:65535];
  logic [7:0] junk;
  logic [7:0] last_read;
  wire  [7:0] rd_value;

  // The unreadable register answers with a value that changes every cycle.
  assign rd_value = (mem.addr == UNREADABLE_ADDR) ? junk : store[mem.addr];

  initial begin
    junk = 8'hA7;
    last_read = 8'h00;
    mem_rdata = 8'h00;
  end

  always @(posedge clk) begin
    junk <= junk + 8'h3B;
    if (mem.wr) begin
      store[mem.addr] <= mem.wdata;
    end
    if (mem.rd) begin
      mem_rdata <= rd_value;
      last_read <= rd_value;
    end else begin
      // Read data lasts one cycle; afterwards the bus alternates between its complement and the stale copy.
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// >>> test/cpu_status_flag_datapath_bench.sv
// Self-checking bench of the status-flag datapath and its memory model.
// Assumes the flag commands take the flag position on bit_sel.
`timescale 1ns/10ps
`include "csf_defs.svh"
module cpu_status_flag_datapath_bench;
  import csf_pkg::*;
  typedef struct {
    logic [2:0] tdc;
    csf_op_type op;
    logic [7:0] acc;
    logic [7:0] data;
    logic [2:0] bs;
    logic [7:0] m;
    logic [7:0] eacc;
    logic [7:0] emem;
    logic [1:0] fc;
    int         lat;
  } csf_row_type;
  localparam logic [15:0] OPND = 16'h0040;
  localparam logic [15:0] UNREAD = 16'h00F0;
  logic            clk;
  logic            rst;
  logic            cmd_valid;
  csf_cmd_type     cmd;
  logic            cmd_ready;
  logic            done;
  csf_mem_req_type mem;
  logic [7:0]      mem_rdata;
  logic [7:0]      ps;
  logic [7:0]      acc;
  logic [7:0]      sp;
  logic            pc_load;
  logic [15:0]     pc_target;
  int              num_errors;
  int              check_count;
  int              cycles;
  int              lat;
  logic            pl;
  logic [7:0]      saved;
  csf_row_type     rows [23];

  csf_core uut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .done(done), .mem(mem), .mem_rdata(mem_rdata),
    .processor_status_register(ps), .acc(acc), .sp(sp),
    .pc_load(pc_load), .pc_target(pc_target));
  csf_mem_model #(.UNREADABLE_ADDR(UNREAD)) model (.clk(clk), .mem(mem),
    .mem_rdata(mem_rdata));

  initial begin
    clk = 1'b0;
  end
  always #12.5 clk = ~clk;

  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    chk16({8'h00, got}, {8'h00, exp});
  endtask

  // Offers one command, waits for done and records its latency.
  // The accept edge counts as cycle one, since register commands raise
  // done at that very edge and drop it at the next.
  task automatic issue(input csf_op_type op, input logic [15:0] a,
                       input logic [7:0] d, input logic [2:0] bs);
    int n;
    cmd_valid = 1'b1;
    cmd = '{op: op, addr: a, data: d, bit_sel: bs};
    lat = 0;
    pl = 1'b0;
    for (n = 1; n <= 20 && lat == 0; n++) begin
      @(posedge clk);
      #2;
      cmd_valid = 1'b0;
      if (done === 1'b1) begin
        lat = n;
        pl = pc_load;
      end
    end
  endtask

  task automatic setf(input int pos, input logic v);
    issue(v ? flag_set_op : flag_clear_op, 16'h0000, 8'h00, 3'(pos));
  endtask

  task automatic do_reset();
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #2;
    rst = 1'b0;
    chk8({7'h00, ps[`CSF_FLAG_I]}, 8'h01);
    chk8(acc, 8'h00);
    chk8(sp, 8'hFF);
    chk8({6'h00, cmd_ready, done}, 8'h02);
    chk16(pc_target, 16'h0000);
  endtask

  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    num_errors = 0;
    check_count = 0;
    cycles = 0;
    rows = '{
    '{3'h1,add_with_carry_op,8'h7F,8'h80,3'h0,8'h00,8'h00,8'h00,2'h2,1},
    '{3'h2,add_with_carry_op,8'h45,8'h38,3'h0,8'h00,8'h83,8'h00,2'h1,1},
    '{3'h3,add_with_carry_op,8'h58,8'h46,3'h0,8'h00,8'h05,8'h00,2'h2,1},
    '{3'h3,subtract_with_borrow_op,8'h42,8'h15,3'h0,8'h00,8'h27,8'h00,2'h2,1},
    '{3'h3,subtract_with_borrow_op,8'h15,8'h42,3'h0,8'h00,8'h73,8'h00,2'h1,1},
    '{3'h0,subtract_with_borrow_op,8'h50,8'h20,3'h0,8'h00,8'h2F,8'h00,2'h2,1},
    '{3'h2,and_op,8'hF0,8'h3C,3'h0,8'h00,8'h30,8'h00,2'h0,1},
    '{3'h4,exclusive_or_op,8'h55,8'hFF,3'h0,8'hF0,8'h55,8'h0F,2'h0,4},
    '{3'h4,inclusive_or_op,8'h55,8'h30,3'h0,8'h0F,8'h55,8'h3F,2'h0,4},
    '{3'h5,add_with_carry_op,8'h55,8'h05,3'h0,8'h10,8'h55,8'h16,2'h1,4},
    '{3'h7,subtract_with_borrow_op,8'h55,8'h15,3'h0,8'h42,8'h55,8'h27,2'h2,4},
    '{3'h0,bit_set_op,8'h55,8'h00,3'h7,8'h01,8'h55,8'h81,2'h0,4},
    '{3'h0,bit_clear_op,8'h55,8'h00,3'h0,8'h81,8'h55,8'h80,2'h0,4},
    '{3'h0,shift_left_op,8'h55,8'h00,3'h0,8'h81,8'h55,8'h02,2'h2,4},
    '{3'h0,shift_right_op,8'h55,8'h00,3'h0,8'h01,8'h55,8'h00,2'h2,4},
    '{3'h1,rotate_left_op,8'h55,8'h00,3'h0,8'h80,8'h55,8'h01,2'h2,4},
    '{3'h0,rotate_right_op,8'h55,8'h00,3'h0,8'h01,8'h55,8'h00,2'h2,4},
    '{3'h0,nibble_rotate_op,8'h55,8'h00,3'h0,8'hA5,8'h55,8'h5A,2'h0,4},
    '{3'h2,increment_op,8'h55,8'h00,3'h0,8'h09,8'h55,8'h0A,2'h0,4},
    '{3'h0,decrement_op,8'h55,8'h00,3'h0,8'h00,8'h55,8'hFF,2'h0,4},
    '{3'h0,ones_complement_op,8'h55,8'h00,3'h0,8'h3C,8'h55,8'hC3,2'h0,4},
    '{3'h6,multiply_op,8'h12,8'h10,3'h0,8'h00,8'h20,8'h00,2'h3,2},
    '{3'h7,divide_op,8'h64,8'h07,3'h0,8'h00,8'h0E,8'h00,2'h3,2}};
    #2;
    do_reset();
    // Status byte round trip through the stack.
    issue(load_stack_op, 16'h0000, 8'h80, 3'h0);
    chk8(sp, 8'h80);
    model.store[{`CSF_STACK_PAGE, 8'h81}] = 8'hE9;
    issue(pull_status_op, 16'h0000, 8'h00, 3'h0);
    chk8(ps, 8'hE9);
    chk8(8'(lat), 8'h03);
    setf(`CSF_FLAG_C, 1'b0);
    issue(push_status_op, 16'h0000, 8'h00, 3'h0);
    chk8(sp, 8'h80);
    chk8(model.store[{`CSF_STACK_PAGE, sp + 8'h01}], 8'hE8);
    setf(`CSF_FLAG_C, 1'b1);
    issue(pull_status_op, 16'h0000, 8'h00, 3'h0);
    chk8(ps, 8'hE8);
    foreach (rows[i]) begin
      setf(`CSF_FLAG_T, rows[i].tdc[2]);
      setf(`CSF_FLAG_D, rows[i].tdc[1]);
      setf(`CSF_FLAG_C, rows[i].tdc[0]);
      issue(load_acc_op, OPND, rows[i].acc, 3'h0);
      model.store[OPND] = rows[i].m;
      saved = ps;
      issue(rows[i].op, OPND, rows[i].data, rows[i].bs);
      chk8(acc, rows[i].eacc);
      chk8(model.store[OPND], rows[i].emem);
      chk8(8'(lat), 8'(rows[i].lat));
      if (rows[i].fc == 2'h1 || rows[i].fc == 2'h2) begin
        chk8({7'h00, ps[`CSF_FLAG_C]}, {7'h00, rows[i].fc[1]});
      end
      if (rows[i].fc == 2'h3) begin
        chk8(ps, saved);
      end
    end
    // Multiply high byte and divide-by-zero remainder go to the stack.
    issue(load_acc_op, OPND, 8'hFF, 3'h0);
    saved = sp;
    issue(multiply_op, OPND, 8'hFF, 3'h0);
    chk8(acc, 8'h01);
    chk8(model.store[{`CSF_STACK_PAGE, saved}], 8'hFE);
    chk8(sp, saved - 8'h01);
    issue(load_acc_op, OPND, 8'h37, 3'h0);
    saved = sp;
    issue(divide_op, OPND, 8'h00, 3'h0);
    chk8(acc, 8'hFF);
    chk8(model.store[{`CSF_STACK_PAGE, saved}], 8'h37);
    // Indirect pointer on the last byte of a page.
    model.store[16'h12FF] = 8'h34;
    model.store[16'h1200] = 8'h56;
    model.store[16'h1300] = 8'h99;
    issue(jump_op, 16'h12FF, 8'h00, 3'h0);
    chk16(pc_target, 16'h5634);
    chk8({7'h00, pl}, 8'h01);
    chk8(8'(lat), 8'h05);
    issue(ones_complement_op, UNREAD, 8'h00, 3'h0);
    chk8(model.store[UNREAD], ~model.last_read);
    // A second reset must bring interrupt disable back.
    setf(`CSF_FLAG_I, 1'b0);
    chk8({7'h00, ps[`CSF_FLAG_I]}, 8'h00);
    do_reset();
    end_of_test();
  end
endmodule
